//--- logic/abcbx_core.sv
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ps
module abcbx_core (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic [7:0]                    paddr,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [31:0]                   pwdata,
  input  wire logic [3:0]                    pstrb,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  output logic      [abcbx_pkg::FADDR_W-1:0] memAddr,
  output logic      [abcbx_pkg::DATA_W-1:0]  memWrData,
  output logic                               memWe,
  input  wire logic [abcbx_pkg::DATA_W-1:0]  memRdData
);

  // ****************************************************************
  // Helpers.
  // ****************************************************************
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    merge = (old & ~m) | (wd & m);
  endfunction

  // ****************************************************************
  // State.
  // ****************************************************************
  abcbx_pkg::abcbx_phase_t        phase;
  abcbx_pkg::abcbx_phase_t        next_phase;
  logic                           inNop;
  logic                           next_inNop;
  logic [abcbx_pkg::INSTR_W-1:0]  instr;
  logic [abcbx_pkg::INSTR_W-1:0]  next_instr;
  logic [abcbx_pkg::DATA_W-1:0]   acc;
  logic [abcbx_pkg::DATA_W-1:0]   next_acc;
  logic [abcbx_pkg::STAT_W-1:0]   status;
  logic [abcbx_pkg::STAT_W-1:0]   next_status;
  logic [abcbx_pkg::PC_W-1:0]     pc;
  logic [abcbx_pkg::PC_W-1:0]     next_pc;
  logic [abcbx_pkg::BANK_W-1:0]   bankPtr;
  logic [abcbx_pkg::BANK_W-1:0]   next_bankPtr;
  logic [abcbx_pkg::FADDR_W-1:0]  indexBase;
  logic [abcbx_pkg::FADDR_W-1:0]  next_indexBase;
  logic                           extEnable;
  logic                           next_extEnable;
  logic [abcbx_pkg::DATA_W-1:0]   fileData;
  logic [abcbx_pkg::DATA_W-1:0]   next_fileData;
  logic [abcbx_pkg::DATA_W-1:0]   resultReg;
  logic [abcbx_pkg::DATA_W-1:0]   next_resultReg;
  logic                           takenReg;
  logic                           next_takenReg;
  logic                           badOp;
  logic                           next_badOp;
  logic [abcbx_pkg::FADDR_W-1:0]  next_memAddr;
  logic [abcbx_pkg::DATA_W-1:0]   next_memWrData;
  logic                           next_memWe;
  logic [31:0]                    next_prdata;
  logic                           next_pslverr;

  logic        busy;
  logic        setup;
  logic        wrAccess;
  logic        known;
  logic [31:0] readMux;
  logic [31:0] wrMerged;

  abcbx_exec_if ex ();

  abcbx_decode_unit i_abcbx_decode_unit (
    .ex (ex.unit)
  );

  assign ex.instr     = instr;
  assign ex.extEnable = extEnable;
  assign ex.bankPtr   = bankPtr;
  assign ex.indexBase = indexBase;
  assign ex.acc       = acc;
  assign ex.fileData  = fileData;
  assign ex.carry     = status[abcbx_pkg::ST_C];
  assign ex.negative  = status[abcbx_pkg::ST_N];
  assign ex.pc        = pc;

  // ****************************************************************
  // Bus decode.
  // ****************************************************************
  assign busy     = (phase != abcbx_pkg::PH_IDLE);
  assign setup    = psel && !penable;
  assign wrAccess = psel && penable && pwrite;
  assign pready   = 1'b1;
  assign wrMerged = merge(readMux, pwdata, pstrb);

  always_comb begin
    known   = 1'b1;
    readMux = 32'h00000000;
    unique case (paddr)
      abcbx_pkg::REG_CTRL:   readMux[abcbx_pkg::CTRL_EXT] = extEnable;
      abcbx_pkg::REG_INSTR:  readMux[15:0] = instr;
      abcbx_pkg::REG_ACC:    readMux[7:0] = acc;
      abcbx_pkg::REG_STATUS: readMux[4:0] = status;
      abcbx_pkg::REG_PC:     readMux[20:0] = pc;
      abcbx_pkg::REG_BANK:   readMux[3:0] = bankPtr;
      abcbx_pkg::REG_INDEX:  readMux[11:0] = indexBase;
      abcbx_pkg::REG_STATE: begin
        readMux[abcbx_pkg::STA_BUSY]       = busy;
        readMux[abcbx_pkg::STA_PHASE +: 3] = phase;
        readMux[abcbx_pkg::STA_NOP]        = inNop;
        readMux[abcbx_pkg::STA_TAKEN]      = takenReg;
        readMux[abcbx_pkg::STA_BADOP]      = badOp;
      end
      default: known = 1'b0;
    endcase
  end

  // ****************************************************************
  // Next values.
  // ****************************************************************
  always_comb begin
    next_phase     = phase;
    next_inNop     = inNop;
    next_instr     = instr;
    next_acc       = acc;
    next_status    = status;
    next_pc        = pc;
    next_bankPtr   = bankPtr;
    next_indexBase = indexBase;
    next_extEnable = extEnable;
    next_fileData  = fileData;
    next_resultReg = resultReg;
    next_takenReg  = takenReg;
    next_badOp     = badOp;
    next_memAddr   = memAddr;
    next_memWrData = memWrData;
    next_memWe     = 1'b0;
    next_prdata    = prdata;
    next_pslverr   = pslverr;

    if (setup) begin
      next_prdata  = known ? readMux : 32'h00000000;
      next_pslverr = !known;
    end

    if (wrAccess && !busy) begin
      unique case (paddr)
        abcbx_pkg::REG_CTRL: begin
          next_extEnable = wrMerged[abcbx_pkg::CTRL_EXT];
        end
        abcbx_pkg::REG_INSTR: begin
          next_instr    = wrMerged[15:0];
          next_phase    = abcbx_pkg::PH_Q1;
          next_inNop    = 1'b0;
          next_takenReg = 1'b0;
          next_badOp    = 1'b0;
        end
        abcbx_pkg::REG_ACC: begin
          next_acc = wrMerged[7:0];
        end
        abcbx_pkg::REG_STATUS: begin
          next_status = wrMerged[4:0];
        end
        abcbx_pkg::REG_PC: begin
          next_pc = wrMerged[20:0];
        end
        abcbx_pkg::REG_BANK: begin
          next_bankPtr = wrMerged[3:0];
        end
        abcbx_pkg::REG_INDEX: begin
          next_indexBase = wrMerged[11:0];
        end
        default: begin
        end
      endcase
    end

    unique case (phase)
      abcbx_pkg::PH_IDLE: begin
      end
      abcbx_pkg::PH_Q1: begin
        next_phase = abcbx_pkg::PH_Q2;
        if (!inNop) begin
          next_pc      = pc + abcbx_pkg::PC_STEP;
          next_memAddr = ex.fileAddr;
          if (ex.kind == abcbx_pkg::OPK_NONE) begin
            next_badOp = 1'b1;
          end
        end
      end
      abcbx_pkg::PH_Q2: begin
        next_phase = abcbx_pkg::PH_Q3;
        if (!inNop) begin
          next_fileData = memRdData;
        end
      end
      abcbx_pkg::PH_Q3: begin
        next_phase = abcbx_pkg::PH_Q4;
        if (!inNop) begin
          next_resultReg = ex.result;
          next_memWrData = ex.result;
          next_memWe     = ex.toFile;
          next_takenReg  = (ex.kind == abcbx_pkg::OPK_BRANCH) && ex.taken;
        end
      end
      abcbx_pkg::PH_Q4: begin
        next_phase = abcbx_pkg::PH_IDLE;
        if (!inNop) begin
          if ((ex.kind == abcbx_pkg::OPK_AND_LIT) ||
              (ex.kind == abcbx_pkg::OPK_AND_FILE)) begin
            if (!ex.toFile) begin
              next_acc = resultReg;
            end
            next_status[abcbx_pkg::ST_Z] = (resultReg == 8'h00);
            next_status[abcbx_pkg::ST_N] = resultReg[7];
          end
          if (takenReg) begin
            next_pc    = ex.target;
            next_phase = abcbx_pkg::PH_Q1;
            next_inNop = 1'b1;
          end
        end else begin
          next_inNop = 1'b0;
        end
      end
      default: begin
        next_phase = abcbx_pkg::PH_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // Registers.
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      phase     <= abcbx_pkg::PH_IDLE;
      inNop     <= 1'b0;
      instr     <= abcbx_pkg::RST_INSTR;
      acc       <= abcbx_pkg::RST_DATA;
      status    <= abcbx_pkg::RST_STAT;
      pc        <= abcbx_pkg::RST_PC;
      bankPtr   <= 4'h0;
      indexBase <= 12'h000;
      extEnable <= 1'b0;
      fileData  <= abcbx_pkg::RST_DATA;
      resultReg <= abcbx_pkg::RST_DATA;
      takenReg  <= 1'b0;
      badOp     <= 1'b0;
      memAddr   <= 12'h000;
      memWrData <= abcbx_pkg::RST_DATA;
      memWe     <= 1'b0;
      prdata    <= 32'h00000000;
      pslverr   <= 1'b0;
    end else begin
      phase     <= next_phase;
      inNop     <= next_inNop;
      instr     <= next_instr;
      acc       <= next_acc;
      status    <= next_status;
      pc        <= next_pc;
      bankPtr   <= next_bankPtr;
      indexBase <= next_indexBase;
      extEnable <= next_extEnable;
      fileData  <= next_fileData;
      resultReg <= next_resultReg;
      takenReg  <= next_takenReg;
      badOp     <= next_badOp;
      memAddr   <= next_memAddr;
      memWrData <= next_memWrData;
      memWe     <= next_memWe;
      prdata    <= next_prdata;
      pslverr   <= next_pslverr;
    end
  end

endmodule // abcbx_core

//--- logic/abcbx_decode_unit.sv
`timescale 1ns/1ps
module abcbx_decode_unit (
  abcbx_exec_if.unit ex
);

  // ****************************************************************
  // Decode, operand address, data path and branch target.
  // ****************************************************************
  logic [7:0] opc;
  logic [7:0] fld;
  logic [7:0] operand;
  logic [7:0] bitMask;

  assign opc = ex.instr[15:8];
  assign fld = ex.instr[7:0];

  always_comb begin
    ex.kind = abcbx_pkg::OPK_NONE;
    if (opc == abcbx_pkg::OP_AND_LIT) begin
      ex.kind = abcbx_pkg::OPK_AND_LIT;
    end else if (opc[7:2] == abcbx_pkg::OP_AND_FILE) begin
      ex.kind = abcbx_pkg::OPK_AND_FILE;
    end else if (opc[7:4] == abcbx_pkg::OP_CLR_BIT) begin
      ex.kind = abcbx_pkg::OPK_CLR_BIT;
    end else if (opc == abcbx_pkg::OP_BR_C || opc == abcbx_pkg::OP_BR_NC ||
                 opc == abcbx_pkg::OP_BR_N || opc == abcbx_pkg::OP_BR_NN) begin
      ex.kind = abcbx_pkg::OPK_BRANCH;
    end
  end

  assign ex.toFile = (ex.kind == abcbx_pkg::OPK_AND_FILE) ? opc[1]
                   : (ex.kind == abcbx_pkg::OPK_CLR_BIT);

  always_comb begin
    if (opc[0]) begin
      ex.fileAddr = {ex.bankPtr, fld};
    end else if (ex.extEnable && fld <= abcbx_pkg::INDEX_MAX) begin
      ex.fileAddr = ex.indexBase + {4'h0, fld};
    end else if (fld < abcbx_pkg::ACCESS_SPLIT) begin
      ex.fileAddr = {abcbx_pkg::ACCESS_LOW, fld};
    end else begin
      ex.fileAddr = {abcbx_pkg::ACCESS_HIGH, fld};
    end
  end

  assign operand = (ex.kind == abcbx_pkg::OPK_AND_LIT) ? fld : ex.fileData;
  assign bitMask = 8'h01 << opc[3:1];
  assign ex.result = (ex.kind == abcbx_pkg::OPK_CLR_BIT)
                   ? (ex.fileData & ~bitMask)
                   : (ex.acc & operand);

  always_comb begin
    unique case (opc)
      abcbx_pkg::OP_BR_C:  ex.taken = ex.carry;
      abcbx_pkg::OP_BR_NC: ex.taken = !ex.carry;
      abcbx_pkg::OP_BR_N:  ex.taken = ex.negative;
      abcbx_pkg::OP_BR_NN: ex.taken = !ex.negative;
      default:             ex.taken = 1'b0;
    endcase
  end

  assign ex.target = ex.pc + {{12{fld[7]}}, fld, 1'b0};

endmodule // abcbx_decode_unit

//--- pkg/abcbx_exec_if.sv
`timescale 1ns/1ps
interface abcbx_exec_if;
  logic [abcbx_pkg::INSTR_W-1:0] instr;
  logic                          extEnable;
  logic [abcbx_pkg::BANK_W-1:0]  bankPtr;
  logic [abcbx_pkg::FADDR_W-1:0] indexBase;
  logic [abcbx_pkg::DATA_W-1:0]  acc;
  logic [abcbx_pkg::DATA_W-1:0]  fileData;
  logic                          carry;
  logic                          negative;
  logic [abcbx_pkg::PC_W-1:0]    pc;
  abcbx_pkg::abcbx_opk_t         kind;
  logic                          toFile;
  logic [abcbx_pkg::FADDR_W-1:0] fileAddr;
  logic [abcbx_pkg::DATA_W-1:0]  result;
  logic                          taken;
  logic [abcbx_pkg::PC_W-1:0]    target;

  modport core (output instr, extEnable, bankPtr, indexBase, acc, fileData,
                output carry, negative, pc,
                input  kind, toFile, fileAddr, result, taken, target);
  modport unit (input  instr, extEnable, bankPtr, indexBase, acc, fileData,
                input  carry, negative, pc,
                output kind, toFile, fileAddr, result, taken, target);
endinterface

//--- pkg/abcbx_pkg.sv
//
// Contract
// - AND-literal opcode 0000 1011 ANDs accumulator with literal, result to accumulator.
// - Both AND instructions change only negative and zero flags.
// - AND-with-file opcode 0001 01da; d=0 writes accumulator, d=1 writes register.
// - Access bit 0 selects access bank; 1 uses bank pointer for bank.
// - Extended set, access bit 0, address at most 95: indexed literal-offset.
// - Each cycle runs decode, operand read, process, result write phases.
// - Branch-on-carry, opcode 1110 0010, branches when carry is 1; flags untouched.
// - Branch-on-no-carry, opcode 1110 0011, branches when carry is 0.
// - Branch-on-negative, printed opcode 0110 1110, branches when negative is 1.
// - Branch-on-non-negative, opcode 1110 0111, branches when negative is 0.
// - Taken branch loads program counter with branch address plus two plus 2n.
// - Branch takes one cycle untaken, two taken; second cycle is empty.
// - Bit-clear opcode 1001 bbba clears one bit by read-modify-write, flags kept.
package abcbx_pkg;

  // ****************************************************************
  // Widths.
  // ****************************************************************
  localparam int DATA_W  = 8;
  localparam int FADDR_W = 12;
  localparam int PC_W    = 21;
  localparam int INSTR_W = 16;
  localparam int BANK_W  = 4;
  localparam int STAT_W  = 5;

  // ****************************************************************
  // Opcodes.
  // ****************************************************************
  localparam logic [7:0] OP_AND_LIT  = 8'h0B;
  localparam logic [5:0] OP_AND_FILE = 6'h05;
  localparam logic [3:0] OP_CLR_BIT  = 4'h9;
  localparam logic [7:0] OP_BR_C     = 8'hE2;
  localparam logic [7:0] OP_BR_NC    = 8'hE3;
  localparam logic [7:0] OP_BR_N     = 8'h6E;
  localparam logic [7:0] OP_BR_NN    = 8'hE7;

  // ****************************************************************
  // Addressing and counter constants.
  // ****************************************************************
  localparam logic [7:0]      INDEX_MAX   = 8'h5F;
  localparam logic [7:0]      ACCESS_SPLIT = 8'h60;
  localparam logic [3:0]      ACCESS_LOW  = 4'h0;
  localparam logic [3:0]      ACCESS_HIGH = 4'hF;
  localparam logic [PC_W-1:0] PC_STEP     = 21'h000002;

  // ****************************************************************
  // Register offsets, fields and reset values.
  // ****************************************************************
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_INSTR  = 8'h04;
  localparam logic [7:0] REG_ACC    = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_PC     = 8'h10;
  localparam logic [7:0] REG_BANK   = 8'h14;
  localparam logic [7:0] REG_INDEX  = 8'h18;
  localparam logic [7:0] REG_STATE  = 8'h1C;

  localparam int CTRL_EXT   = 0;
  localparam int ST_C       = 0;
  localparam int ST_DC      = 1;
  localparam int ST_Z       = 2;
  localparam int ST_OV      = 3;
  localparam int ST_N       = 4;
  localparam int STA_BUSY   = 0;
  localparam int STA_PHASE  = 1;
  localparam int STA_NOP    = 4;
  localparam int STA_TAKEN  = 5;
  localparam int STA_BADOP  = 6;

  localparam logic [DATA_W-1:0]  RST_DATA = 8'h00;
  localparam logic [STAT_W-1:0]  RST_STAT = 5'h00;
  localparam logic [PC_W-1:0]    RST_PC   = 21'h000000;
  localparam logic [INSTR_W-1:0] RST_INSTR = 16'h0000;

  // ****************************************************************
  // Types.
  // ****************************************************************
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_Q1   = 3'b001,
    PH_Q2   = 3'b010,
    PH_Q3   = 3'b011,
    PH_Q4   = 3'b100
  } abcbx_phase_t;

  typedef enum logic [2:0] {
    OPK_NONE     = 3'b000,
    OPK_AND_LIT  = 3'b001,
    OPK_AND_FILE = 3'b010,
    OPK_CLR_BIT  = 3'b011,
    OPK_BRANCH   = 3'b100
  } abcbx_opk_t;

endpackage

//--- tb/abcbx_core_properties.sv
`timescale 1ns/1ps
module abcbx_core_properties (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [11:0] memAddr,
  input wire logic [7:0]  memWrData,
  input wire logic        memWe,
  input wire logic [7:0]  memRdData
);
  // ****************************************************************
  // Shadow of the instruction phase and the addressing registers.
  // ****************************************************************
  logic [2:0]  cnt, next_cnt;
  logic [15:0] ins, next_ins;
  logic [3:0]  bank, next_bank;
  logic        ext, next_ext;
  logic [11:0] idx, next_idx, expAddr;
  logic [7:0]  rdCap, next_rdCap, f;
  logic        wrR, wrI, isClr, isAndF, isF, unmap;

  always_comb begin
    wrR = psel && penable && pwrite && pready && cnt == 3'h0;
    wrI = wrR && paddr == abcbx_pkg::REG_INSTR;
    unmap = paddr[1:0] != 2'h0 || paddr > 8'h1C;
    f = ins[7:0];
    isClr = ins[15:12] == abcbx_pkg::OP_CLR_BIT;
    isAndF = ins[15:10] == abcbx_pkg::OP_AND_FILE;
    isF = isClr || isAndF;
    next_cnt = (cnt == 3'h0 || cnt == 3'h4) ? 3'h0 : cnt + 3'h1;
    next_ins = ins;
    next_bank = bank;
    next_ext = ext;
    next_idx = idx;
    if (wrI) begin
      next_cnt = 3'h1;
      next_ins = pwdata[15:0];
    end
    if (wrR && pstrb[0] && paddr == abcbx_pkg::REG_BANK) next_bank = pwdata[3:0];
    if (wrR && pstrb[0] && paddr == abcbx_pkg::REG_CTRL) next_ext = pwdata[0];
    if (wrR && pstrb[0] && paddr == abcbx_pkg::REG_INDEX) next_idx = pwdata[11:0];
    next_rdCap = (cnt == 3'h2) ? memRdData : rdCap;
    if (ins[8]) expAddr = {bank, f};
    else if (ext && f <= 8'h5F) expAddr = idx + {4'h0, f};
    else if (f < 8'h60) expAddr = {4'h0, f};
    else expAddr = {4'hF, f};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= 3'h0;
      ins <= 16'h0000;
      bank <= 4'h0;
      ext <= 1'b0;
      idx <= 12'h000;
      rdCap <= 8'h00;
    end else begin
      cnt <= next_cnt;
      ins <= next_ins;
      bank <= next_bank;
      ext <= next_ext;
      idx <= next_idx;
      rdCap <= next_rdCap;
    end
  end

  // ****************************************************************
  // Properties.
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_we_in_q4: assert property (memWe |-> cnt == 3'h4)
    else $error("memory write outside the fourth phase");
  a_we_pulse: assert property (memWe |=> !memWe)
    else $error("memory write longer than one cycle");
  a_file_we: assert property (wrI && (pwdata[15:12] == 4'h9
    || pwdata[15:9] == 7'h0B) |-> ##1 !memWe [*3] ##1 memWe)
    else $error("register write-back missing in the fourth phase");
  a_acc_no_we: assert property (wrI && (pwdata[15:8] == 8'h0B
    || pwdata[15:9] == 7'h0A) |-> ##1 !memWe [*4])
    else $error("memory written by an accumulator operation");
  a_br_no_we: assert property (wrI && pwdata[15:8] inside
    {8'hE2, 8'hE3, 8'h6E, 8'hE7} |-> ##1 !memWe [*8])
    else $error("memory written by a branch");
  a_addr_map: assert property (cnt == 3'h2 && isF
    |-> memAddr == expAddr)
    else $error("wrong data memory address");
  a_addr_hold: assert property (cnt == 3'h2 && isF
    |=> $stable(memAddr) [*2])
    else $error("memory address moved before the write");
  a_clr_data: assert property (cnt == 3'h4 && isClr
    |-> memWrData == (rdCap & ~(8'h01 << ins[11:9])))
    else $error("bit clear wrote a wrong value");
  a_and_data: assert property (cnt == 3'h4 && isAndF && ins[9]
    |-> (memWrData & ~rdCap) == 8'h00)
    else $error("AND result holds bits absent from the register");
  a_err_map: assert property (psel && !penable
    |=> pslverr == $past(unmap))
    else $error("slave error does not match the address map");

  c_instr: cover property (wrI);
  c_write: cover property (memWe);
  c_error: cover property (pslverr);
endmodule // abcbx_core_properties

bind abcbx_core abcbx_core_properties i_abcbx_core_properties (
  .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .memAddr(memAddr),
  .memWrData(memWrData), .memWe(memWe), .memRdData(memRdData));

//--- tb/abcbx_core_tb.sv
`timescale 1ns/1ps
module abcbx_core_tb;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, memWe, er;
  logic [7:0]  paddr, memWrData, memRdData;
  logic [31:0] pwdata, prdata, rv;
  logic [3:0]  pstrb;
  logic [11:0] memAddr;
  logic [7:0]  mem [0:4095];
  logic [15:0] bi [8] = '{16'hE205, 16'hE205, 16'hE380, 16'hE380,
                         16'h6E7F, 16'h6E7F, 16'hE7FB, 16'hE7FB};
  logic [4:0]  bs [8] = '{5'h01, 5'h1E, 5'h1E, 5'h01,
                         5'h10, 5'h0F, 5'h0F, 5'h10};
  int          fails, comparisons;

  abcbx_core i_abcbx_core (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .memAddr(memAddr),
    .memWrData(memWrData), .memWe(memWe), .memRdData(memRdData));

  // ****************************************************************
  // Data memory and clock.
  // ****************************************************************
  assign memRdData = mem[memAddr];
  always @(posedge clk) if (memWe) mem[memAddr] <= memWrData;

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ****************************************************************
  // Bus tasks and compares.
  // ****************************************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask

  task automatic chkErr(input logic g, input logic e);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t slave error %b want %b", $time, g, e);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fails++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rv, er);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000, rv, er);
    chk(rv, e);
  endtask

  task automatic idle;
    int n;
    n = 0;
    do begin
      apb(1'b0, abcbx_pkg::REG_STATE, 32'h00000000, rv, er);
      n++;
    end while (rv[0] !== 1'b0 && n < 20);
    chk({31'h0, rv[0]}, 32'h00000000);
  endtask

  task automatic exec(input logic [15:0] i, input logic [31:0] st);
    wr(abcbx_pkg::REG_INSTR, {16'h0000, i});
    repeat (4) @(posedge clk);
    apb(1'b0, abcbx_pkg::REG_STATE, 32'h00000000, rv, er);
    chk(rv & 32'h00000071, st);
    idle;
  endtask

  task automatic fcase(input logic [31:0] c, input logic [15:0] i,
                       input logic [11:0] a, input logic [7:0] mi, me,
                       input logic [7:0] ai, ae, input logic [4:0] si, se);
    mem[a] = mi;
    wr(abcbx_pkg::REG_CTRL, c);
    wr(abcbx_pkg::REG_BANK, 32'h00000003);
    wr(abcbx_pkg::REG_INDEX, 32'h00000200);
    wr(abcbx_pkg::REG_ACC, {24'h000000, ai});
    wr(abcbx_pkg::REG_STATUS, {27'h0000000, si});
    wr(abcbx_pkg::REG_PC, 32'h00000100);
    exec(i, 32'h00000000);
    chk({24'h000000, mem[a]}, {24'h000000, me});
    rdc(abcbx_pkg::REG_ACC, {24'h000000, ae});
    rdc(abcbx_pkg::REG_STATUS, {27'h0000000, se});
    rdc(abcbx_pkg::REG_PC, 32'h00000102);
  endtask

  task automatic bcase(input logic [15:0] i, input logic [4:0] st,
                       input logic t);
    logic [31:0] pcExp;
    pcExp = 32'h00001002;
    if (t) pcExp = (pcExp + {{23{i[7]}}, i[7:0], 1'b0}) & 32'h001FFFFF;
    wr(abcbx_pkg::REG_STATUS, {27'h0000000, st});
    wr(abcbx_pkg::REG_PC, 32'h00001000);
    exec(i, t ? 32'h00000031 : 32'h00000000);
    rdc(abcbx_pkg::REG_PC, pcExp);
    rdc(abcbx_pkg::REG_STATUS, {27'h0000000, st});
  endtask

  task automatic end_sim;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ****************************************************************
  // Test sequence.
  // ****************************************************************
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    pstrb = 4'hF;
    fails = 0;
    comparisons = 0;
    for (int i = 0; i < 4096; i++) mem[i] = 8'h00;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) rdc(8'(i * 4), 32'h00000000);
    apb(1'b0, 8'h20, 32'h00000000, rv, er);
    chkErr(er, 1'b1);
    chk(rv, 32'h00000000);
    $display("test reset done");
    fcase(0, 16'h0B5F, 12'h7FF, 8'h00, 8'h00, 8'hA3, 8'h03, 5'h0B, 5'h0B);
    fcase(0, 16'h0B80, 12'h7FF, 8'h00, 8'h00, 8'hF0, 8'h80, 5'h0B, 5'h1B);
    fcase(0, 16'h0B0F, 12'h7FF, 8'h00, 8'h00, 8'h30, 8'h00, 5'h0B, 5'h0F);
    wr(abcbx_pkg::REG_ACC, 32'h000000F0);
    wr(abcbx_pkg::REG_INSTR, 32'h00000B3C);
    wr(abcbx_pkg::REG_ACC, 32'h000000FF);
    idle;
    rdc(abcbx_pkg::REG_ACC, 32'h00000030);
    $display("test literal done");
    fcase(0, 16'h1420, 12'h020, 8'hC2, 8'hC2, 8'h17, 8'h02, 5'h1F, 5'h0B);
    fcase(0, 16'h1740, 12'h340, 8'hF0, 8'h80, 8'h8F, 8'h8F, 5'h00, 5'h10);
    fcase(0, 16'h1680, 12'hF80, 8'h0F, 8'h00, 8'hF0, 8'hF0, 5'h0B, 5'h0F);
    fcase(1, 16'h165F, 12'h25F, 8'h3C, 8'h0C, 8'h0F, 8'h0F, 5'h00, 5'h00);
    fcase(1, 16'h1660, 12'hF60, 8'h55, 8'h05, 8'h0F, 8'h0F, 5'h00, 5'h00);
    $display("test file done");
    fcase(0, 16'h9E30, 12'h030, 8'hC7, 8'h47, 8'h5A, 8'h5A, 5'h1F, 5'h1F);
    fcase(0, 16'h9112, 12'h312, 8'hFF, 8'hFE, 8'h5A, 8'h5A, 5'h00, 5'h00);
    $display("test bit clear done");
    for (int i = 0; i < 8; i++) bcase(bi[i], bs[i], i[0] == 1'b0);
    exec(16'hFF00, 32'h00000040);
    rdc(abcbx_pkg::REG_STATE, 32'h00000040);
    rdc(abcbx_pkg::REG_PC, 32'h00001004);
    $display("test branch done");
    end_sim;
  end

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    $display("[ERR] %0t watchdog expired", $time);
    end_sim;
  end
endmodule // abcbx_core_tb
